/* verilog/pio_defs.svh */
// Purpose: Constants for the pattern I/O control front end.
// Assumes: 50 MHz system clock; register offsets are byte addresses.
// Notes:   Pulse counts derive from nanosecond figures and the clock rate.
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

`define PIO_CLK_MHZ         50
`define PIO_REQ_IN_LOW_NS   50
`define PIO_ACK_IN_LOW_NS   100
`define PIO_REQ_OUT_LOW_NS  100
`define PIO_ACK_OUT_LOW_NS  100
// A pulse "longer than" a time needs one cycle beyond the rounded-down count.
`define PIO_MORE_THAN_CYC(ns) ((((ns) * `PIO_CLK_MHZ) / 1000) + 1)
// A driven pulse of a fixed length rounds down, never below one cycle.
`define PIO_HOLD_CYC(ns) (((((ns) * `PIO_CLK_MHZ) / 1000) < 1) ? 1 : (((ns) * `PIO_CLK_MHZ) / 1000))

`define PIO_ADR_CTRL    8'h00
`define PIO_ADR_CMD     8'h04
`define PIO_ADR_DOUT    8'h08
`define PIO_ADR_DIN     8'h0C
`define PIO_ADR_STATUS  8'h10
`define PIO_ADR_IRQ_CLR 8'h14
`define PIO_ADR_IRQ_EN  8'h18

`define PIO_CTRL_DIR       1:0
`define PIO_CTRL_GP        2
`define PIO_CTRL_IN_HS     3
`define PIO_CTRL_OUT_HS    4
`define PIO_CTRL_IN_GO_R   5
`define PIO_CTRL_IN_HALT_R 6
`define PIO_CTRL_OUT_GO_R  7
`define PIO_CTRL_OUT_HLT_R 8
`define PIO_CTRL_RST       32'h0000_0000

`define PIO_CMD_IN_START   0
`define PIO_CMD_IN_STOP    1
`define PIO_CMD_OUT_START  2
`define PIO_CMD_OUT_STOP   3

`define PIO_ST_LINES       3:0
`define PIO_ST_IN_RUN      8
`define PIO_ST_OUT_RUN     9
`define PIO_ST_CAP_VALID   10
`define PIO_ST_STAGED      11

`define PIO_LINE_IRQS      3:0
`define PIO_HALF_UP        31:16
`define PIO_WORD_RST       32'h0000_0000
`define PIO_NIB_RST        4'h0

`endif

/* verilog/pio_pkg.sv */
// Purpose: Types for the pattern I/O control front end.
// Assumes: Nothing beyond SystemVerilog packages.
// Notes:   Control pin groups travel as one packed struct per direction.
package pio_pkg;

    typedef enum logic [1:0] {
        dir_all_input,
        dir_half_split,
        dir_all_output
    } pio_dir_type;

    // The hs member is the active-low request (input side) or acknowledge (output side).
    typedef struct packed {
        logic pacer;
        logic go;
        logic halt;
        logic hs;
    } pio_ctl_type;

    typedef enum {in_idle, in_write, in_ack, in_release} pio_in_st_type;

    typedef enum {out_idle, out_req, out_wait, out_done} pio_out_st_type;

endpackage : pio_pkg

/* verilog/pio_front.sv */
// Purpose: Direction, interrupts and external control of a 32-line pattern port.
// Assumes: Wishbone classic slave on clk_i; all pins are asynchronous to clk_i.
// Notes:   The transfer engine sits outside and meets this block at cap_* and gen_*.
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "pio_defs.svh"

// Behaviour
// - Software sets direction in 16-line halves.
// - Same direction setting for both usage modes.
// - General mode: four low lines, rising-edge interrupts.
// - Five control signals for each pattern direction.
// - Pacer clock falling edge moves one word.
// - Selected edge of go starts transfer.
// - Selected edge of halt stops transfer.
// - Request and acknowledge are active low.
// - Input accepted after request low beyond 50ns.
// - Accepted word goes to host memory write.
// - Acknowledge low 100ns after write completes.
// - Output presents data, request low 100ns.
// - Acknowledge low beyond 100ns completes; prefetch early.
// - Line interrupts merge into one output.
// - Each line interrupt is enabled separately.
module pio_front
    import pio_pkg::*;
#(
    parameter int CW = 4
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic [31:0] data_i,
    output logic      [31:0] data_o,
    output logic      [31:0] data_oe_o,
    input  wire pio_ctl_type in_ctl_i,
    output logic             in_hs_acknowledge_n_o,
    input  wire pio_ctl_type out_ctl_i,
    output logic             out_hs_request_n_o,
    output logic             in_run_o,
    output logic             out_run_o,
    output logic      [31:0] cap_data_o,
    output logic             cap_valid_o,
    input  wire logic        cap_done_i,
    input  wire logic [31:0] gen_data_i,
    input  wire logic        gen_valid_i,
    output logic             gen_ready_o
);

    localparam logic [CW-1:0] REQ_IN_CYC  = CW'(`PIO_MORE_THAN_CYC(`PIO_REQ_IN_LOW_NS));
    localparam logic [CW-1:0] ACK_IN_CYC  = CW'(`PIO_HOLD_CYC(`PIO_ACK_IN_LOW_NS));
    localparam logic [CW-1:0] REQ_OUT_CYC = CW'(`PIO_HOLD_CYC(`PIO_REQ_OUT_LOW_NS));
    localparam logic [CW-1:0] ACK_OUT_CYC = CW'(`PIO_MORE_THAN_CYC(`PIO_ACK_OUT_LOW_NS));

    logic [39:0]    sync1_q, sync2_q, sync3_q;
    pio_ctl_type    in_s, in_p, out_s, out_p;
    logic [31:0]    din_s, din_p;
    logic [31:0]    ctrl_q, dout_q, pat_q, stage_q, rd_d, wmask;
    logic [3:0]     st_q, en_q, cmd_d, clr_d;
    logic           gp_mode, in_hs_sel, out_hs_sel, stage_full_q;
    logic           in_go_ev, in_halt_ev, out_go_ev, out_halt_ev;
    logic           in_run_q, out_run_q, cap_valid_q, take_gen, wr_go;
    logic [CW-1:0]  in_cnt_q, out_cnt_q;
    pio_dir_type    dir;
    pio_in_st_type  in_st_q;
    pio_out_st_type out_st_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Stage one feeds stage two only; edges are found between stages two and three.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_q <= 40'h00_0000_0000;
            sync2_q <= 40'h00_0000_0000;
            sync3_q <= 40'h00_0000_0000;
        end else begin
            sync1_q <= {data_i, in_ctl_i, out_ctl_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign {din_s, in_s, out_s} = sync2_q;
    assign {din_p, in_p, out_p} = sync3_q;

    assign dir        = pio_dir_type'(ctrl_q[`PIO_CTRL_DIR]);
    assign gp_mode    = ctrl_q[`PIO_CTRL_GP];
    assign in_hs_sel  = ctrl_q[`PIO_CTRL_IN_HS];
    assign out_hs_sel = ctrl_q[`PIO_CTRL_OUT_HS];

    // One direction field serves general and pattern use alike.
    always_comb begin
        case (dir)
            dir_half_split: data_oe_o = {16'hFFFF, 16'h0000};
            dir_all_output: data_oe_o = 32'hFFFF_FFFF;
            default:        data_oe_o = 32'h0000_0000;
        endcase
    end

    assign data_o = gp_mode ? dout_q : pat_q;

    // Start and stop edges; software commands act the same way.
    assign in_go_ev    = ctrl_q[`PIO_CTRL_IN_GO_R] ? (in_s.go & ~in_p.go)
                                                   : (in_p.go & ~in_s.go);
    assign in_halt_ev  = ctrl_q[`PIO_CTRL_IN_HALT_R] ? (in_s.halt & ~in_p.halt)
                                                     : (in_p.halt & ~in_s.halt);
    assign out_go_ev   = ctrl_q[`PIO_CTRL_OUT_GO_R] ? (out_s.go & ~out_p.go)
                                                    : (out_p.go & ~out_s.go);
    assign out_halt_ev = ctrl_q[`PIO_CTRL_OUT_HLT_R] ? (out_s.halt & ~out_p.halt)
                                                     : (out_p.halt & ~out_s.halt);

    // A stop in the same cycle as a start wins, so a halted run never restarts by accident.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_run_q  <= 1'b0;
            out_run_q <= 1'b0;
        end else begin
            if (in_halt_ev || cmd_d[`PIO_CMD_IN_STOP])
                in_run_q <= 1'b0;
            else if (in_go_ev || cmd_d[`PIO_CMD_IN_START])
                in_run_q <= 1'b1;
            if (out_halt_ev || cmd_d[`PIO_CMD_OUT_STOP])
                out_run_q <= 1'b0;
            else if (out_go_ev || cmd_d[`PIO_CMD_OUT_START])
                out_run_q <= 1'b1;
        end
    end

    assign in_run_o  = in_run_q;
    assign out_run_o = out_run_q;

    // Input side: pacer capture or request/acknowledge handshake.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_st_q     <= in_idle;
            in_cnt_q    <= '0;
            cap_valid_q <= 1'b0;
            cap_data_o  <= `PIO_WORD_RST;
        end else begin
            if (cap_done_i)
                cap_valid_q <= 1'b0;
            case (in_st_q)
                in_idle: begin
                    if (in_run_q && !in_hs_sel && in_p.pacer && !in_s.pacer) begin
                        cap_data_o  <= din_s;
                        cap_valid_q <= 1'b1;
                    end else if (in_run_q && in_hs_sel && !in_s.hs) begin
                        // Shorter low pulses are glitches; no data moves before this.
                        if (in_cnt_q == REQ_IN_CYC - 1'b1) begin
                            cap_data_o  <= din_s;
                            cap_valid_q <= 1'b1;
                            in_cnt_q    <= '0;
                            in_st_q     <= in_write;
                        end else begin
                            in_cnt_q <= in_cnt_q + 1'b1;
                        end
                    end else begin
                        in_cnt_q <= '0;
                    end
                end
                in_write: begin
                    if (cap_done_i)
                        in_st_q <= in_ack;
                end
                in_ack: begin
                    if (in_cnt_q == ACK_IN_CYC - 1'b1) begin
                        in_cnt_q <= '0;
                        in_st_q  <= in_release;
                    end else begin
                        in_cnt_q <= in_cnt_q + 1'b1;
                    end
                end
                in_release: begin
                    // Waiting for request high stops one long pulse counting twice.
                    if (in_s.hs)
                        in_st_q <= in_idle;
                end
                default: in_st_q <= in_idle;
            endcase
        end
    end

    assign cap_valid_o           = cap_valid_q;
    assign in_hs_acknowledge_n_o = (in_st_q != in_ack);

    // Output side: word taken from the engine by pacer, idle handshake or early prefetch.
    assign take_gen = gen_valid_i && (
        (out_run_q && !out_hs_sel && out_p.pacer && !out_s.pacer && out_st_q == out_idle) ||
        (out_run_q && out_hs_sel && out_st_q == out_idle && !stage_full_q) ||
        (out_st_q == out_wait && out_p.hs && !out_s.hs && !stage_full_q));
    assign gen_ready_o = take_gen;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_st_q     <= out_idle;
            out_cnt_q    <= '0;
            pat_q        <= `PIO_WORD_RST;
            stage_q      <= `PIO_WORD_RST;
            stage_full_q <= 1'b0;
        end else begin
            case (out_st_q)
                out_idle: begin
                    out_cnt_q <= '0;
                    if (out_run_q && !out_hs_sel && take_gen) begin
                        pat_q <= gen_data_i;
                    end else if (out_run_q && out_hs_sel && stage_full_q) begin
                        pat_q        <= stage_q;
                        stage_full_q <= 1'b0;
                        out_st_q     <= out_req;
                    end else if (take_gen) begin
                        pat_q    <= gen_data_i;
                        out_st_q <= out_req;
                    end
                end
                out_req: begin
                    if (out_cnt_q == REQ_OUT_CYC - 1'b1) begin
                        out_cnt_q <= '0;
                        out_st_q  <= out_wait;
                    end else begin
                        out_cnt_q <= out_cnt_q + 1'b1;
                    end
                end
                out_wait: begin
                    if (take_gen) begin
                        stage_q      <= gen_data_i;
                        stage_full_q <= 1'b1;
                    end
                    if (out_s.hs) begin
                        out_cnt_q <= '0;
                    end else if (out_cnt_q == ACK_OUT_CYC - 1'b1) begin
                        out_cnt_q <= '0;
                        out_st_q  <= out_done;
                    end else begin
                        out_cnt_q <= out_cnt_q + 1'b1;
                    end
                end
                out_done: begin
                    if (out_s.hs)
                        out_st_q <= out_idle;
                end
                default: out_st_q <= out_idle;
            endcase
        end
    end

    assign out_hs_request_n_o = (out_st_q != out_req);

    // Register bus: ack one cycle after the request, write at the ack edge.
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign cmd_d = (wr_go && wb_adr_i == `PIO_ADR_CMD) ? (wb_dat_i[3:0] & wmask[3:0]) : 4'h0;
    assign clr_d = (wr_go && wb_adr_i == `PIO_ADR_IRQ_CLR) ? (wb_dat_i[3:0] & wmask[3:0])
                                                            : 4'h0;

    always_comb begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            `PIO_ADR_CTRL:   rd_d = ctrl_q;
            `PIO_ADR_DOUT:   rd_d = dout_q;
            `PIO_ADR_DIN:    rd_d = din_s;
            `PIO_ADR_IRQ_EN: rd_d[`PIO_LINE_IRQS] = en_q;
            `PIO_ADR_STATUS: begin
                rd_d[`PIO_ST_LINES]     = st_q;
                rd_d[`PIO_ST_IN_RUN]    = in_run_q;
                rd_d[`PIO_ST_OUT_RUN]   = out_run_q;
                rd_d[`PIO_ST_CAP_VALID] = cap_valid_q;
                rd_d[`PIO_ST_STAGED]    = stage_full_q;
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `PIO_WORD_RST;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o)
                wb_dat_o <= rd_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `PIO_CTRL_RST;
            dout_q <= `PIO_WORD_RST;
            en_q   <= `PIO_NIB_RST;
        end else if (wr_go) begin
            if (wb_adr_i == `PIO_ADR_CTRL)
                ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i & wmask);
            if (wb_adr_i == `PIO_ADR_DOUT)
                dout_q <= (dout_q & ~wmask) | (wb_dat_i & wmask);
            if (wb_adr_i == `PIO_ADR_IRQ_EN && wb_sel_i[0])
                en_q <= wb_dat_i[`PIO_LINE_IRQS];
        end
    end

    // Sticky line events; a new edge in the clearing cycle survives.
    always_ff @(posedge clk_i) begin
        if (rst_i)
            st_q <= `PIO_NIB_RST;
        else if (gp_mode && dir != dir_all_output)
            st_q <= (st_q & ~clr_d) | (din_s[`PIO_LINE_IRQS] & ~din_p[`PIO_LINE_IRQS]);
        else
            st_q <= st_q & ~clr_d;
    end

    assign irq_o = |(st_q & en_q);

    a_dir_all_out: assert property (dir == dir_all_output |-> data_oe_o == 32'hFFFF_FFFF)
        else $error("All-output setting does not drive every line.");
    a_dir_split: assert property (dir == dir_half_split |-> data_oe_o == 32'hFFFF_0000)
        else $error("Split setting drives the wrong half.");
    a_line_irq_rise: assert property (
        gp_mode && dir == dir_all_input && en_q[0] && din_s[0] && !din_p[0] |=> irq_o)
        else $error("Enabled line rising edge did not raise the interrupt.");
    a_irq_masked: assert property (en_q == 4'h0 |-> !irq_o)
        else $error("Interrupt raised with every source disabled.");
    a_go_starts: assert property (
        in_go_ev && !in_halt_ev && cmd_d == 4'h0 |=> in_run_q)
        else $error("Selected start edge did not start input transfer.");
    a_halt_stops: assert property (out_halt_ev |=> !out_run_q)
        else $error("Selected stop edge did not stop output transfer.");
    a_pacer_capture: assert property (
        in_st_q == in_idle && in_run_q && !in_hs_sel && in_p.pacer && !in_s.pacer
        |=> cap_valid_q && cap_data_o == $past(din_s))
        else $error("Pacer falling edge did not capture the input word.");
    a_req_accept: assert property (
        $rose(cap_valid_q) && in_hs_sel && !$past(in_s.pacer & ~in_p.pacer)
        |-> $past(!in_s.hs, 1) && $past(!in_s.hs, 2) && $past(!in_s.hs, 3))
        else $error("Input word accepted before request was low long enough.");
    a_ack_after_write: assert property (
        in_st_q == in_write && cap_done_i |=> !in_hs_acknowledge_n_o)
        else $error("Acknowledge did not follow the completed write.");
    a_ack_pulse_len: assert property (
        $fell(in_hs_acknowledge_n_o) |-> !in_hs_acknowledge_n_o[*5] ##1 in_hs_acknowledge_n_o)
        else $error("Input acknowledge low time is not 100 ns.");
    a_req_pulse_len: assert property (
        $fell(out_hs_request_n_o) |-> !out_hs_request_n_o[*5] ##1 out_hs_request_n_o)
        else $error("Output request low time is not 100 ns.");
    a_ack_complete: assert property (
        out_st_q == out_wait && !out_s.hs |-> ##[0:6] (out_st_q == out_done || out_s.hs))
        else $error("Long acknowledge low pulse not taken as completion.");

    c_hs_input:  cover property (in_st_q == in_ack ##1 in_st_q == in_release);
    c_hs_output: cover property (out_st_q == out_done ##[1:20] out_st_q == out_req);
    c_prefetch:  cover property (out_st_q == out_wait && take_gen);
    c_irq:       cover property ($rose(irq_o));

endmodule : pio_front

/* test/pio_ext_dev.sv */
// Purpose: Model of the external pattern device on the front end's pins.
// Assumes: Changes land just after clk_i rising edges; a pacer period of 160 ns is 8 clocks.
// Notes:   Data lines hold the last word put; the front end's own drive is not looped back.
`timescale 1ns/10ps
module pio_ext_dev
    import pio_pkg::*;
#(
    parameter int ACK_CYC = 7
) (
    input  wire logic        clk_i,
    input  wire logic        out_hs_request_n_i,
    output pio_ctl_type      in_ctl_o,
    output pio_ctl_type      out_ctl_o,
    output logic      [31:0] data_o
);
    pio_ctl_type out_q;
    logic        ack_n_q;
    int          cnt_q;

    initial begin
        in_ctl_o = 4'h1;
        out_q    = 4'h1;
        ack_n_q  = 1'b1;
        cnt_q    = 0;
        data_o   = 32'h0000_0000;
    end

    assign out_ctl_o = {out_q.pacer, out_q.go, out_q.halt, ack_n_q};

    // Ack stays low one cycle past the 6-cycle threshold so jitter cannot cut it short.
    always @(posedge clk_i) begin
        if (cnt_q == 0) begin
            cnt_q <= (out_hs_request_n_i === 1'b0) ? 1 : 0;
        end else begin
            cnt_q <= (cnt_q == ACK_CYC + 2) ? 0 : cnt_q + 1;
        end
        ack_n_q <= !(cnt_q >= 2 && cnt_q < ACK_CYC + 2);
    end

    task automatic hold(input int c);
        repeat (c) @(posedge clk_i);
    endtask : hold

    // Toggles one control pin and keeps the new level for c cycles.
    task automatic pulse(input bit o, input int b, input int c);
        if (o) begin
            out_q[b] <= ~out_q[b];
        end else begin
            in_ctl_o[b] <= ~in_ctl_o[b];
        end
        hold(c);
    endtask : pulse

    task automatic put(input logic [31:0] w);
        data_o <= w;
    endtask : put
endmodule : pio_ext_dev

/* test/tb.sv */
// Purpose: Self-checking bench for the pattern port front end.
// Assumes: 50 MHz clock; every request and pin change lands just after a rising edge.
// Notes:   The bench plays the transfer engine at cap_* and gen_* itself.
`timescale 1ns/10ps
`include "pio_defs.svh"
module tb
    import pio_pkg::*;
;
    logic        clk_i     = 1'b0;
    logic        rst_i     = 1'b1;
    logic [7:0]  adr       = 8'h00;
    logic [31:0] wdat      = 32'h0000_0000;
    logic        we        = 1'b0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic [3:0]  sel       = 4'hF;
    logic [3:0]  bsel      = 4'hF;
    logic        cap_done  = 1'b0;
    logic [31:0] gen_data  = 32'h1111_1111;
    logic        gen_valid = 1'b0;
    logic [31:0] rdat, rd, dout, oe, cap_data, dev_data, d;
    logic        ack, irq, in_ack_n, out_req_n, in_run, out_run, cap_valid, gen_ready;
    pio_ctl_type in_ctl, out_ctl;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          len;

    always #10 clk_i = ~clk_i;

    pio_front i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .irq_o(irq), .data_i(dev_data), .data_o(dout), .data_oe_o(oe),
        .in_ctl_i(in_ctl), .in_hs_acknowledge_n_o(in_ack_n), .out_ctl_i(out_ctl),
        .out_hs_request_n_o(out_req_n), .in_run_o(in_run), .out_run_o(out_run),
        .cap_data_o(cap_data), .cap_valid_o(cap_valid), .cap_done_i(cap_done),
        .gen_data_i(gen_data), .gen_valid_i(gen_valid), .gen_ready_o(gen_ready));

    pio_ext_dev i_dev (.clk_i(clk_i), .out_hs_request_n_i(out_req_n), .in_ctl_o(in_ctl),
        .out_ctl_o(out_ctl), .data_o(dev_data));

    // The engine offers the next word as soon as the front end takes one.
    always @(posedge clk_i) begin
        if (gen_ready === 1'b1) begin
            gen_data <= gen_data + 32'h1111_1111;
        end
    end

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    task automatic bound(input int n, input int lim);
        if (n >= lim) begin
            error_cnt++;
            give_verdict();
        end
    endtask : bound

    // The request stands until ack is sampled high; cyc then idles one cycle.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
        int n;
        adr  <= a;
        we   <= w;
        wdat <= v;
        sel  <= bsel;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        @(posedge clk_i);
        for (n = 0; ack !== 1'b1 && n < 64; n++) @(posedge clk_i);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        bound(n, 64);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        bus(a, 1'b1, v);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0000_0000);
        chk(rd, e);
    endtask : rdc

    function automatic logic sig(input int k);
        case (k)
            0: return in_run;
            1: return out_run;
            2: return cap_valid;
            default: return irq;
        endcase
    endfunction : sig

    task automatic wait_is(input int k, input logic v);
        int n;
        for (n = 0; n < 64 && sig(k) !== v; n++) @(posedge clk_i);
        bound(n, 64);
        chk({31'h0, sig(k)}, {31'h0, v});
    endtask : wait_is

    // Six cycles cover the synchroniser, the edge detect and the run flag update.
    task automatic ev(input bit o, input int b, input int k, input logic v);
        i_dev.pulse(o, b, 6);
        chk({31'h0, sig(k)}, {31'h0, v});
    endtask : ev

    task automatic low_len(input bit w, output int n_low, output logic [31:0] dat);
        int n;
        n_low = 0;
        for (n = 0; n < 200 && (w ? out_req_n : in_ack_n) !== 1'b0; n++) @(posedge clk_i);
        bound(n, 200);
        dat = dout;
        while ((w ? out_req_n : in_ack_n) === 1'b0 && n_low < 20) begin
            @(posedge clk_i);
            n_low++;
        end
    endtask : low_len

    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, error_cnt);
    endtask : done

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({30'h0, in_ack_n, out_req_n}, 32'h0000_0003);
        rdc(`PIO_ADR_CTRL, 32'h0000_0000);
        wr(8'h1C, 32'hFFFF_FFFF);
        rdc(8'h1C, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            wr(`PIO_ADR_CTRL, 32'(k));
            chk(oe, k[1:0] == 2'h1 ? 32'hFFFF_0000 : k[1:0] == 2'h2 ? 32'hFFFF_FFFF : 32'h0);
        end
        wr(`PIO_ADR_CTRL, 32'h0000_0005);
        wr(`PIO_ADR_DOUT, 32'h1234_5678);
        chk(dout, 32'h1234_5678);
        // Only the two low byte lanes are enabled, so the upper half must keep its value.
        bsel = 4'h3;
        wr(`PIO_ADR_DOUT, 32'hFFFF_FFFF);
        bsel = 4'hF;
        chk(dout, 32'h1234_FFFF);
        done("direction");
        wr(`PIO_ADR_CTRL, 32'h0000_0004);
        wr(`PIO_ADR_IRQ_EN, 32'h0000_0005);
        i_dev.put(32'h0000_000F);
        i_dev.hold(6);
        rdc(`PIO_ADR_STATUS, 32'h0000_000F);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`PIO_ADR_IRQ_CLR, 32'h0000_0005);
        rdc(`PIO_ADR_STATUS, 32'h0000_000A);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(`PIO_ADR_IRQ_EN, 32'h0000_000A);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`PIO_ADR_IRQ_CLR, 32'h0000_000F);
        wr(`PIO_ADR_CTRL, 32'h0000_0006);
        i_dev.put(32'h0000_0000);
        i_dev.hold(6);
        i_dev.put(32'h0000_000F);
        i_dev.hold(6);
        rdc(`PIO_ADR_STATUS, 32'h0000_0000);
        done("interrupts");
        wr(`PIO_ADR_CTRL, 32'h0000_0120);
        ev(0, 2, 0, 1'b1);
        ev(0, 2, 0, 1'b1);
        ev(0, 1, 0, 1'b1);
        ev(0, 1, 0, 1'b0);
        ev(1, 2, 1, 1'b0);
        ev(1, 2, 1, 1'b1);
        ev(1, 1, 1, 1'b0);
        done("start and stop");
        wr(`PIO_ADR_CTRL, 32'h0000_0000);
        wr(`PIO_ADR_CMD, 32'h0000_0001);
        wait_is(0, 1'b1);
        i_dev.put(32'hA5A5_5A5A);
        i_dev.pulse(0, 3, 4);
        chk({31'h0, cap_valid}, 32'h0000_0000);
        i_dev.pulse(0, 3, 4);
        wait_is(2, 1'b1);
        chk(cap_data, 32'hA5A5_5A5A);
        cap_done <= 1'b1;
        @(posedge clk_i);
        cap_done <= 1'b0;
        wait_is(2, 1'b0);
        done("input pacer");
        wr(`PIO_ADR_CTRL, 32'h0000_0008);
        i_dev.put(32'hC3C3_3C3C);
        i_dev.pulse(0, 0, 2);
        i_dev.pulse(0, 0, 6);
        chk({31'h0, cap_valid}, 32'h0000_0000);
        i_dev.pulse(0, 0, 1);
        wait_is(2, 1'b1);
        chk(cap_data, 32'hC3C3_3C3C);
        i_dev.hold(8);
        chk({31'h0, in_ack_n}, 32'h0000_0001);
        cap_done <= 1'b1;
        @(posedge clk_i);
        cap_done <= 1'b0;
        low_len(0, len, d);
        chk(len, 5);
        i_dev.pulse(0, 0, 5);
        i_dev.put(32'h3C3C_C3C3);
        done("input handshake");
        wr(`PIO_ADR_CTRL, 32'h0000_0011);
        gen_valid <= 1'b1;
        wr(`PIO_ADR_CMD, 32'h0000_0004);
        low_len(1, len, d);
        chk(len, 5);
        chk(d, 32'h1111_1111);
        low_len(1, len, d);
        chk(d, 32'h2222_2222);
        chk(len, 5);
        wr(`PIO_ADR_CMD, 32'h0000_0008);
        gen_valid <= 1'b0;
        i_dev.hold(30);
        // The stop leaves one prefetched word staged while input pacing still runs.
        rdc(`PIO_ADR_STATUS, 32'h0000_0900);
        done("output handshake");
        wr(`PIO_ADR_CTRL, 32'h0000_0002);
        gen_valid <= 1'b1;
        wr(`PIO_ADR_CMD, 32'h0000_0004);
        i_dev.pulse(1, 3, 4);
        chk(dout, 32'h2222_2222);
        i_dev.pulse(1, 3, 4);
        chk(dout, 32'h4444_4444);
        chk({31'h0, out_req_n}, 32'h0000_0001);
        wr(`PIO_ADR_CMD, 32'h0000_0008);
        gen_valid <= 1'b0;
        done("output pacer");
        give_verdict();
    end
endmodule : tb
